//--- rtl/fbo_pkg.sv
// Package for the flash bus host controller: timing, widths and carrier types
package fbo_pkg;

  // Clock period in ns (20 MHz)
  localparam int CLK_NS = 50;
  // Access, write pulse and deselect times in ns
  localparam int RANDOM_ACCESS_NS = 90;
  localparam int SELECT_ACCESS_NS = 90;
  localparam int PAGE_ACCESS_NS = 25;
  localparam int WRITE_PULSE_NS = 35;
  localparam int DESELECT_NS = 35;
  // Least times round up to whole cycles
  localparam int FULL_CYC = (((RANDOM_ACCESS_NS > SELECT_ACCESS_NS) ? RANDOM_ACCESS_NS
                              : SELECT_ACCESS_NS) + CLK_NS - 1) / CLK_NS;
  localparam int PAGE_CYC = (PAGE_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int DESEL_CYC = (DESELECT_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;

  // Address layout: word address bits 21..0, sector bits 21..12, page bits 21..2
  localparam int ADDR_W = 22;
  localparam int SECT_LSB = 12;
  localparam int PAGE_LSB = 2;

  // Request from the user side
  typedef struct packed {
    logic write;
    logic byte_mode;
    logic [ADDR_W-1:0] addr;
    logic low_addr;
    logic [15:0] wdata;
  } fbo_req_t;

  // Pin outputs toward the flash
  typedef struct packed {
    logic select_n;
    logic gate_n;
    logic wstrobe_n;
    logic reset_n;
    logic width_word;
    logic protect_n;
    logic [ADDR_W-1:0] addr;
  } fbo_pins_t;

  // Controller states
  typedef enum logic [2:0] {
    FBO_IDLE,
    FBO_READ,
    FBO_WRITE,
    FBO_RECOVER,
    FBO_RESET
  } fbo_state_t;

endpackage

//--- rtl/fbo_host.sv
// Host-side controller that drives a parallel NOR flash through its pins
// Overview of operation
// RULE_01 - Device latches commands internally, unmapped
// RULE_02 - Latched command steers device state machine
// RULE_03 - Word address 21..0, byte adds lowest bit
// RULE_04 - Protect pin low keeps end sector protected
// RULE_05 - Protect pin high follows group protection
// RULE_06 - Sectors start unprotected
// RULE_07 - Width pin high gives sixteen data pins
// RULE_08 - Width pin low gives low byte only
// RULE_09 - Byte width: top data pin carries low address
// RULE_10 - Read holds select, gate low, strobe high
// RULE_11 - Select powers device, gate enables outputs
// RULE_12 - Reset returns device to array read
// RULE_13 - Array read needs no command
// RULE_14 - Page of four words, chosen by bits 21..2
// RULE_15 - Low address bits pick word or byte
// RULE_16 - Page reads are clockless
// RULE_17 - First page access full time, later short
// RULE_18 - Reselect forces full access time
// RULE_19 - Fast page: hold page bits constant
// RULE_20 - Write: strobe and select low, gate high
// RULE_21 - Gate high floats device data pins
// RULE_22 - Reset pin low aborts and floats
// RULE_23 - Deselected device floats outputs
`timescale 1ns/1ps
module fbo_host #(
  parameter int ADDR_W = fbo_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // User request side
  input wire logic req_valid,
  output logic req_ready,
  input wire fbo_pkg::fbo_req_t req,
  input wire logic flash_reset_req,
  input wire logic protect_req,
  output logic [15:0] rdata,
  output logic rdata_valid,
  output logic busy,
  // Flash pins
  output fbo_pkg::fbo_pins_t pins,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic [15:0] dq_oe
);

  // Two-flop synchroniser for the data pins
  logic [15:0] dq_s1;
  logic [15:0] dq_s2;
  always_ff @(posedge clk)
  begin
    dq_s1 <= dq_in;
    dq_s2 <= dq_s1;
  end

  // Page-hit test on the word address
  function automatic logic same_page(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    same_page = (a[ADDR_W-1:fbo_pkg::PAGE_LSB] == b[ADDR_W-1:fbo_pkg::PAGE_LSB]);
  endfunction

  fbo_pkg::fbo_state_t state, next_state;
  fbo_pkg::fbo_pins_t next_pins;
  logic [fbo_pkg::CNT_W-1:0] cnt, next_cnt;
  logic page_open, next_page_open;
  logic byte_mode, next_byte_mode;
  logic low_addr, next_low_addr;
  logic [15:0] next_dq_out, next_dq_oe, next_rdata;
  logic next_rdata_valid;

  // Accept only when idle; handshake may be combinational
  assign req_ready = (state == fbo_pkg::FBO_IDLE) && !flash_reset_req;
  assign busy = (state != fbo_pkg::FBO_IDLE);

  // Next-state logic for the bus sequencer
  always_comb
  begin
    next_state = state;
    next_pins = pins;
    next_cnt = cnt;
    next_page_open = page_open;
    next_byte_mode = byte_mode;
    next_low_addr = low_addr;
    next_dq_out = dq_out;
    next_dq_oe = dq_oe;
    next_rdata = rdata;
    next_rdata_valid = 1'b0;
    next_pins.protect_n = !protect_req; // RULE_04 RULE_05
    unique case (state)
      fbo_pkg::FBO_IDLE:
      begin
        next_pins.wstrobe_n = 1'b1;
        next_pins.gate_n = 1'b1;
        if (flash_reset_req)
        begin
          // Abort: release pins, pulse device reset, page no longer valid
          next_pins.reset_n = 1'b0; // RULE_22 RULE_12
          next_pins.select_n = 1'b1;
          next_dq_oe = 16'h0000;
          next_page_open = 1'b0;
          next_cnt = fbo_pkg::CNT_W'(fbo_pkg::FULL_CYC);
          next_state = fbo_pkg::FBO_RESET;
        end
        else if (req_valid)
        begin
          next_pins.addr = req.addr; // RULE_03
          next_pins.width_word = !req.byte_mode; // RULE_07 RULE_08
          next_byte_mode = req.byte_mode;
          next_low_addr = req.low_addr;
          next_pins.select_n = 1'b0;
          if (req.write)
          begin
            // Command cycle: strobe and select low, gate held high
            next_pins.wstrobe_n = 1'b0; // RULE_20 RULE_01
            next_dq_out = req.wdata;
            next_dq_oe = req.byte_mode ? 16'h80FF : 16'hFFFF;
            if (req.byte_mode)
            begin
              next_dq_out[15] = req.low_addr; // RULE_09
            end
            next_page_open = 1'b0; // Command may change device state
            next_cnt = fbo_pkg::CNT_W'(fbo_pkg::WRITE_CYC);
            next_state = fbo_pkg::FBO_WRITE;
          end
          else
          begin
            // Read: gate low, strobe high; byte mode drives only the low addr bit
            next_pins.gate_n = 1'b0; // RULE_10 RULE_13
            next_dq_oe = req.byte_mode ? 16'h8000 : 16'h0000; // RULE_09 RULE_21
            next_dq_out = {req.low_addr, 15'h0000};
            // Short wait only on a page hit with select kept low
            if (page_open && !pins.select_n && same_page(req.addr, pins.addr)
                && req.byte_mode == byte_mode) // RULE_17 RULE_19 RULE_14 RULE_16
            begin
              next_cnt = fbo_pkg::CNT_W'(fbo_pkg::PAGE_CYC + 2);
            end
            else
            begin
              next_cnt = fbo_pkg::CNT_W'(fbo_pkg::FULL_CYC + 2); // RULE_18
            end
            next_state = fbo_pkg::FBO_READ;
          end
        end
        else
        begin
          // Stay selected for page hits; select held means no reselect penalty
          next_dq_oe = 16'h0000;
        end
      end
      fbo_pkg::FBO_READ:
      begin
        // Count includes two synchroniser stages
        if (cnt == fbo_pkg::CNT_W'(1))
        begin
          next_rdata = byte_mode ? {8'h00, dq_s2[7:0]} : dq_s2; // RULE_15 RULE_11
          next_rdata_valid = 1'b1;
          next_pins.gate_n = 1'b1;
          next_dq_oe = 16'h0000;
          next_page_open = 1'b1;
          next_state = fbo_pkg::FBO_IDLE;
        end
        else
        begin
          next_cnt = cnt - fbo_pkg::CNT_W'(1);
        end
      end
      fbo_pkg::FBO_WRITE:
      begin
        if (cnt == fbo_pkg::CNT_W'(1))
        begin
          // Raise strobe first; data held one more cycle for hold time
          next_pins.wstrobe_n = 1'b1; // RULE_02
          next_cnt = fbo_pkg::CNT_W'(fbo_pkg::DESEL_CYC);
          next_state = fbo_pkg::FBO_RECOVER;
        end
        else
        begin
          next_cnt = cnt - fbo_pkg::CNT_W'(1);
        end
      end
      fbo_pkg::FBO_RECOVER:
      begin
        // Deselect after a write so the next read pays full time
        next_pins.select_n = 1'b1; // RULE_23
        next_dq_oe = 16'h0000;
        if (cnt == fbo_pkg::CNT_W'(1))
        begin
          next_state = fbo_pkg::FBO_IDLE;
        end
        else
        begin
          next_cnt = cnt - fbo_pkg::CNT_W'(1);
        end
      end
      fbo_pkg::FBO_RESET:
      begin
        if (cnt == fbo_pkg::CNT_W'(1))
        begin
          next_pins.reset_n = 1'b1;
          next_state = fbo_pkg::FBO_IDLE;
        end
        else
        begin
          next_cnt = cnt - fbo_pkg::CNT_W'(1);
        end
      end
      default:
      begin
        next_state = fbo_pkg::FBO_IDLE;
      end
    endcase
  end

  // Register stage; the reset pin stays high so the device keeps its own
  // protection state (RULE_06 needs no action from the host)
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state <= fbo_pkg::FBO_IDLE;
      pins <= '{select_n: 1'b1, gate_n: 1'b1, wstrobe_n: 1'b1, reset_n: 1'b1,
                width_word: 1'b1, protect_n: 1'b1, addr: '0}; // RULE_06
      cnt <= '0;
      page_open <= 1'b0;
      byte_mode <= 1'b0;
      low_addr <= 1'b0;
      dq_out <= 16'h0000;
      dq_oe <= 16'h0000;
      rdata <= 16'h0000;
      rdata_valid <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pins <= next_pins;
      cnt <= next_cnt;
      page_open <= next_page_open;
      byte_mode <= next_byte_mode;
      low_addr <= next_low_addr;
      dq_out <= next_dq_out;
      dq_oe <= next_dq_oe;
      rdata <= next_rdata;
      rdata_valid <= next_rdata_valid;
    end
  end

  // Read cycle never drives the strobe and keeps select low
  a_read_levels: assert property (@(posedge clk) disable iff (!nrst) // RULE_10
    state == fbo_pkg::FBO_READ |-> pins.wstrobe_n && !pins.select_n && !pins.gate_n)
    else $error("read cycle pin levels wrong");

  // Write cycle keeps the gate high while strobing
  a_write_gate: assert property (@(posedge clk) disable iff (!nrst) // RULE_20
    !pins.wstrobe_n |-> pins.gate_n && !pins.select_n)
    else $error("write strobe with gate low");

  // Host never drives low data pins while the device gate is open
  a_no_contend: assert property (@(posedge clk) disable iff (!nrst) // RULE_21
    !pins.gate_n |-> dq_oe[14:0] == 15'h0000)
    else $error("host drives data while gate low");

  // Byte-mode read drives the low address bit on the top pin
  a_byte_low: assert property (@(posedge clk) disable iff (!nrst) // RULE_09
    (state == fbo_pkg::FBO_READ && byte_mode) |-> dq_oe[15] && dq_out[15] == low_addr)
    else $error("low address bit not driven");

  // Reset request pulses the reset pin low with the chip deselected
  a_reset_pulse: assert property (@(posedge clk) disable iff (!nrst) // RULE_22
    (state == fbo_pkg::FBO_IDLE && flash_reset_req) |=> !pins.reset_n && pins.select_n)
    else $error("reset pulse missing");

  // Fresh read after deselect waits the full access time
  a_full_time: assert property (@(posedge clk) disable iff (!nrst) // RULE_18
    (state == fbo_pkg::FBO_IDLE && req_valid && req_ready && !req.write && pins.select_n)
    |=> cnt == fbo_pkg::CNT_W'(fbo_pkg::FULL_CYC + 2))
    else $error("full access time not applied");

  // Width pin follows the requested mode during a read
  a_width_pin: assert property (@(posedge clk) disable iff (!nrst) // RULE_07
    state == fbo_pkg::FBO_READ |-> pins.width_word == !byte_mode)
    else $error("width pin mismatch");

  // Protect pin follows the request one cycle later
  a_protect: assert property (@(posedge clk) disable iff (!nrst) // RULE_04
    protect_req |=> !pins.protect_n)
    else $error("protect pin not low");

endmodule

//--- tb/fbo_flash_model.sv
// Behavioural flash device that answers the host controller's pins
`timescale 1ns/1ps
module fbo_flash_model (
  // Bookkeeping clock; the device itself is clockless
  input wire logic clk,
  // Pins from the host
  input wire fbo_pkg::fbo_pins_t pins,
  input wire logic [15:0] dq_out,
  input wire logic [15:0] dq_oe,
  // Resolved data bus
  output logic [15:0] dq_in
);
  logic [15:0] mem [0:15];
  logic [23:0] tag;
  logic [23:0] last_tag = '0;
  logic [19:0] open_page = '0;
  logic page_open = 1'h0;
  logic last_we = 1'h1;
  logic flt = 1'h0;
  logic a_m1, drive, hit;
  logic [15:0] word, dev;
  int cnt = 0;
  int elapsed;
  // Every location starts unprotected and readable
  initial for (int i = 0; i < 16; i++) mem[i] = 16'hC3A0 + 16'(i);
  assign a_m1 = dq_oe[15] ? dq_out[15] : flt;
  assign tag = {pins.select_n, pins.addr, pins.width_word ? 1'h0 : a_m1};
  assign elapsed = (tag != last_tag) ? 0 : cnt + 1;
  assign hit = page_open && (open_page == pins.addr[21:2]);
  assign drive = !pins.select_n && !pins.gate_n && pins.reset_n && pins.wstrobe_n;
  assign word = mem[pins.addr[3:0]];
  // A wrong value shows until the access time has run, so early sampling is caught
  always_comb
  begin
    dev = pins.width_word ? word : {8'h00, a_m1 ? word[15:8] : word[7:0]};
    if (elapsed < (hit ? fbo_pkg::PAGE_CYC : fbo_pkg::FULL_CYC) - 1) dev = ~dev;
  end
  // Released bits show a pattern that changes every cycle
  always_comb
  begin
    for (int i = 0; i < 16; i++)
      dq_in[i] = dq_oe[i] ? dq_out[i] :
                 (drive && (pins.width_word || i < 8)) ? dev[i] : flt ^ i[0];
  end
  // Access timing, page tracking and array writes on the strobe rising edge
  always @(posedge clk)
  begin
    flt <= ~flt;
    last_tag <= tag;
    last_we <= pins.wstrobe_n;
    cnt <= (elapsed > 8) ? 8 : elapsed;
    if (!pins.reset_n || pins.select_n) page_open <= 1'h0;
    else if (drive && elapsed >= fbo_pkg::FULL_CYC - 1)
    begin
      page_open <= 1'h1;
      open_page <= pins.addr[21:2];
    end
    if (pins.reset_n && !pins.select_n && pins.gate_n && !last_we && pins.wstrobe_n
        && (pins.protect_n || pins.addr[21:12] != 10'h000))
      mem[pins.addr[3:0]] <= dq_in;
  end
endmodule

//--- tb/tb_fbo_host.sv
// Self-checking bench for the flash host controller against the device model
`timescale 1ns/1ps
module tb_fbo_host;
  typedef struct packed {
    logic wr;
    logic bm;
    logic pr;
    logic [21:0] addr;
    logic la;
    logic [15:0] wd;
    logic [15:0] exp;
  } fbo_row_t;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic req_valid = 1'h0;
  logic flash_reset_req = 1'h0;
  logic protect_req = 1'h0;
  fbo_pkg::fbo_req_t req = '0;
  logic req_ready, rdata_valid, busy;
  logic [15:0] rdata, dq_in, dq_out, dq_oe;
  fbo_pkg::fbo_pins_t pins;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  // Ordinary cases: write, read back in both widths, protected sector
  localparam fbo_row_t ROWS [9] = '{
    '{1'h1, 1'h0, 1'h0, 22'h001005, 1'h0, 16'h5A3C, 16'h0000},
    '{1'h0, 1'h0, 1'h0, 22'h001005, 1'h0, 16'h0000, 16'h5A3C},
    '{1'h0, 1'h1, 1'h0, 22'h001005, 1'h0, 16'h0000, 16'h003C},
    '{1'h0, 1'h1, 1'h0, 22'h001005, 1'h1, 16'h0000, 16'h005A},
    '{1'h0, 1'h0, 1'h0, 22'h000006, 1'h0, 16'h0000, 16'hC3A6},
    '{1'h1, 1'h0, 1'h1, 22'h000006, 1'h0, 16'h1111, 16'h0000},
    '{1'h0, 1'h0, 1'h1, 22'h000006, 1'h0, 16'h0000, 16'hC3A6},
    '{1'h1, 1'h0, 1'h0, 22'h000007, 1'h0, 16'h1234, 16'h0000},
    '{1'h0, 1'h0, 1'h0, 22'h000007, 1'h0, 16'h0000, 16'h1234}};

  always #25 clk = ~clk;

  fbo_host dut (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .flash_reset_req(flash_reset_req), .protect_req(protect_req),
    .rdata(rdata), .rdata_valid(rdata_valid), .busy(busy), .pins(pins),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  fbo_flash_model flash (.clk(clk), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_in));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One user request; n counts edges until read data or idle
  task automatic run(input fbo_row_t r);
    @(negedge clk);
    while (!req_ready) @(negedge clk);
    protect_req = r.pr;
    req = '{r.wr, r.bm, r.addr, r.la, r.wd};
    req_valid = 1'h1;
    @(negedge clk);
    req_valid = 1'h0;
    n = 0;
    while (r.wr ? busy : !rdata_valid)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n == 2 && !r.wr) check(dq_oe, {r.bm, 15'h0000});
      if (n == 2 && !r.wr) check({15'h0000, pins.width_word}, {15'h0000, !r.bm});
    end
    if (!r.wr) check(rdata, r.exp);
  endtask

  // Cycle ceiling and bus-level watch on the control pins
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (nrst && !pins.wstrobe_n) check({15'h0000, pins.gate_n}, 16'h0001);
    if (nrst && !pins.gate_n) check({15'h0000, pins.wstrobe_n}, 16'h0001);
    // Ceiling last, so nothing runs after the closing report
    if (cycles == 2000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (20) @(negedge clk);
    check({12'h000, pins.select_n, pins.gate_n, pins.wstrobe_n, pins.reset_n}, 16'h000F);
    check(dq_oe, 16'h0000);
    nrst = 1'h1;
    foreach (ROWS[i]) run(ROWS[i]);
    // Page reuse is short only while select stays low
    run('{1'h0, 1'h0, 1'h0, 22'h002008, 1'h0, 16'h0000, 16'hC3A8});
    check(16'(n), 16'(fbo_pkg::FULL_CYC + 2));
    run('{1'h0, 1'h0, 1'h0, 22'h00200A, 1'h0, 16'h0000, 16'hC3AA});
    check(16'(n), 16'(fbo_pkg::PAGE_CYC + 2));
    run('{1'h1, 1'h0, 1'h0, 22'h002009, 1'h0, 16'h0F0F, 16'h0000});
    run('{1'h0, 1'h0, 1'h0, 22'h00200A, 1'h0, 16'h0000, 16'hC3AA});
    check(16'(n), 16'(fbo_pkg::FULL_CYC + 2));
    // Device reset pulse refuses user requests while asked for
    @(negedge clk);
    flash_reset_req = 1'h1;
    #1;
    check({15'h0000, req_ready}, 16'h0000);
    @(negedge clk);
    flash_reset_req = 1'h0;
    @(negedge clk);
    check({15'h0000, pins.reset_n}, 16'h0000);
    run('{1'h0, 1'h0, 1'h0, 22'h001005, 1'h0, 16'h0000, 16'h5A3C});
    // Controller reset between runs, with select still low, returns the pins to idle
    @(negedge clk);
    nrst = 1'h0;
    @(negedge clk);
    check({12'h000, pins.select_n, pins.gate_n, pins.wstrobe_n, pins.reset_n}, 16'h000F);
    nrst = 1'h1;
    // First read after the controller reset starts deselected, so it pays full time
    run('{1'h0, 1'h0, 1'h0, 22'h001005, 1'h0, 16'h0000, 16'h5A3C});
    check(16'(n), 16'(fbo_pkg::FULL_CYC + 2));
    report_and_stop();
  end
endmodule
